// >>> core/fpa_pkg.sv
// Constants, carrier types and helpers for the frame-pulse alignment control block
package fpa_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 8;
  localparam logic [15:0] ADDR_UPDATE  = 16'h0005;
  localparam logic [15:0] ADDR_ENABLE  = 16'h0640;
  localparam logic [15:0] ADDR_SETTING = 16'h0641;
  localparam logic [15:0] ADDR_STATUS  = 16'h0642;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         BIT_UPDATE   = 0;
  localparam int         BIT_ENABLE   = 0;
  localparam int         BIT_SOFT_ARM = 0;
  localparam int         BIT_ARM_SRC  = 1;
  localparam int         BIT_ONE_SHOT = 2;
  localparam int         BIT_VALIDATE = 3;
  localparam int         ST_ARMED     = 0;
  localparam int         ST_ENABLE    = 1;
  localparam int         ST_DONE      = 2;
  localparam int         ST_PIN       = 3;
  localparam logic [7:0] RST_ENABLE   = 8'h00;
  localparam logic [7:0] RST_SETTING  = 8'h00;

  // ****************************************************************
  // Pin indices of the synchroniser bank
  // ****************************************************************
  localparam int PIN_B    = 0;
  localparam int PIN_D    = 1;
  localparam int PIN_ARM  = 2;
  localparam int NUM_PINS = 3;

  // Register bus request from the master
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fpa_bus_req_type;

  // Alignment configuration, shadow or active copy
  typedef struct packed {
    logic enable;
    logic validate;
    logic one_shot;
    logic arm_src;
    logic soft_arm;
  } fpa_cfg_type;

  // Builds a configuration from the two register bytes
  function automatic fpa_cfg_type fpa_cfg_from_bytes(input logic [7:0] en_byte, input logic [7:0] set_byte);
    fpa_cfg_type c;
    c.enable   = en_byte[BIT_ENABLE];
    c.validate = set_byte[BIT_VALIDATE];
    c.one_shot = set_byte[BIT_ONE_SHOT];
    c.arm_src  = set_byte[BIT_ARM_SRC];
    c.soft_arm = set_byte[BIT_SOFT_ARM];
    return c;
  endfunction

  // Builds the setting byte; reserved bits read zero
  function automatic logic [7:0] fpa_setting_byte(input fpa_cfg_type c);
    logic [7:0] b;
    b               = 8'h00;
    b[BIT_VALIDATE] = c.validate;
    b[BIT_ONE_SHOT] = c.one_shot;
    b[BIT_ARM_SRC]  = c.arm_src;
    b[BIT_SOFT_ARM] = c.soft_arm;
    return b;
  endfunction

  localparam fpa_cfg_type CFG_RST = fpa_cfg_from_bytes(RST_ENABLE, RST_SETTING);

endpackage

// >>> core/fpa_pin_sync.sv
// Two-flop synchroniser with edge detection for one external pin
`timescale 1ns/100ps
module fpa_pin_sync (
  input  logic clk_sys_i,
  input  logic rst_i,
  input  logic ce_i,
  input  logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Synchroniser chain plus one history stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (ce_i) begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges seen only on the second stage
  assign level_o = sync_reg;
  assign rise_o  = sync_reg & ~prev_reg;
  assign fall_o  = ~sync_reg & prev_reg;

  a_fall_one_cycle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (ce_i && fall_o) |=> !fall_o)
    else $error("falling event lasted more than one cycle");

endmodule

// >>> core/fpa_frame_align_ctrl.sv
// Frame-pulse alignment control: buffered registers, arming, one-shot and validity gating
`timescale 1ns/100ps
module fpa_frame_align_ctrl (
  input  logic                     clk_sys_i,
  input  logic                     rst_i,
  input  logic                     ce_i,
  input  fpa_pkg::fpa_bus_req_type bus_req_i,
  output logic [7:0]               rd_data_o,
  input  logic                     arm_pin_i,
  input  logic                     pulse_b_i,
  input  logic                     pulse_d_i,
  input  logic                     ref_a_valid_i,
  input  logic                     ref_b_valid_i,
  input  logic                     ref_c_valid_i,
  input  logic                     ref_d_valid_i,
  input  logic                     ref_c_selected_i,
  output logic                     ref_a_valid_o,
  output logic                     ref_c_valid_o,
  output logic                     frame_align_o,
  output logic                     armed_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [fpa_pkg::NUM_PINS-1:0] pins_raw;
  logic [fpa_pkg::NUM_PINS-1:0] pin_level;
  logic [fpa_pkg::NUM_PINS-1:0] pin_rise;
  logic [fpa_pkg::NUM_PINS-1:0] pin_fall;

  fpa_pkg::fpa_cfg_type shadow_reg;
  fpa_pkg::fpa_cfg_type cfg_reg;
  fpa_pkg::fpa_cfg_type cfg_eff;

  logic       wr_enable;
  logic       wr_setting;
  logic       update_stb;
  logic       soft_arm_evt;
  logic       soft_disarm;
  logic       pin_arm_evt;
  logic       arm_evt;
  logic       pulse_edge;
  logic       align_fire;
  logic       armed_reg;
  logic       armed_next;
  logic       done_reg;
  logic       align_reg;
  logic       ref_a_valid_reg;
  logic       ref_c_valid_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic [7:0] status_byte;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Raw pins gathered by index
  assign pins_raw[fpa_pkg::PIN_B]   = pulse_b_i;
  assign pins_raw[fpa_pkg::PIN_D]   = pulse_d_i;
  assign pins_raw[fpa_pkg::PIN_ARM] = arm_pin_i;

  // One synchroniser per external pin
  for (genvar g = 0; g < fpa_pkg::NUM_PINS; g++) begin : g_pin
    fpa_pin_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .pin_i     (pins_raw[g]),
      .level_o   (pin_level[g]),
      .rise_o    (pin_rise[g]),
      .fall_o    (pin_fall[g])
    );
  end

  // ****************************************************************
  // Register bus decode
  // ****************************************************************

  // Write strobes per register
  assign wr_enable  = bus_req_i.wr && (bus_req_i.addr == fpa_pkg::ADDR_ENABLE);
  assign wr_setting = bus_req_i.wr && (bus_req_i.addr == fpa_pkg::ADDR_SETTING);

  assign update_stb = bus_req_i.wr && (bus_req_i.addr == fpa_pkg::ADDR_UPDATE) &&
                      bus_req_i.wdata[fpa_pkg::BIT_UPDATE];

  // Shadow copy written by software, not yet acting
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      shadow_reg <= fpa_pkg::CFG_RST;
    end else if (ce_i) begin
      if (wr_enable) begin
        shadow_reg.enable <= bus_req_i.wdata[fpa_pkg::BIT_ENABLE];
      end
      if (wr_setting) begin
        shadow_reg.validate <= bus_req_i.wdata[fpa_pkg::BIT_VALIDATE];
        shadow_reg.one_shot <= bus_req_i.wdata[fpa_pkg::BIT_ONE_SHOT];
        shadow_reg.arm_src  <= bus_req_i.wdata[fpa_pkg::BIT_ARM_SRC];
        shadow_reg.soft_arm <= bus_req_i.wdata[fpa_pkg::BIT_SOFT_ARM];
      end
    end
  end

  // active copy loads only on update
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_reg <= fpa_pkg::CFG_RST;
    end else if (ce_i && update_stb) begin
      cfg_reg <= shadow_reg;
    end
  end

  // Configuration in force from the next edge on
  assign cfg_eff = update_stb ? shadow_reg : cfg_reg;

  // ****************************************************************
  // Arming
  // ****************************************************************

  assign soft_arm_evt = update_stb && shadow_reg.arm_src && shadow_reg.soft_arm &&
                        !(cfg_reg.arm_src && cfg_reg.soft_arm);

  // soft bit zero at update disarms when the soft source is selected
  assign soft_disarm = update_stb && shadow_reg.arm_src && !shadow_reg.soft_arm;

  assign pin_arm_evt = !cfg_eff.arm_src && pin_fall[fpa_pkg::PIN_ARM];

  // source select picks one arm path
  assign arm_evt = cfg_eff.arm_src ? soft_arm_evt : pin_arm_evt;

  // armed state, arm wins over consume
  always_comb begin
    armed_next = armed_reg;
    if (!cfg_eff.enable) begin
      armed_next = 1'b0;
    end else if (arm_evt) begin
      armed_next = 1'b1;
    end else if (soft_disarm || (align_fire && cfg_reg.one_shot)) begin
      armed_next = 1'b0;
    end
  end

  // Armed flag register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else if (ce_i) begin
      armed_reg <= armed_next;
    end
  end

  // One-shot used up since last arm
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else if (ce_i) begin
      if (arm_evt) begin
        done_reg <= 1'b0;
      end else if (align_fire && cfg_reg.one_shot) begin
        done_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Alignment pulse
  // ****************************************************************

  // pulse taken from B, or D when C is in use
  assign pulse_edge = cfg_reg.enable &&
                      (ref_c_selected_i ? pin_rise[fpa_pkg::PIN_D] : pin_rise[fpa_pkg::PIN_B]);

  // level mode fires on every edge, one-shot only while armed
  assign align_fire = pulse_edge && (!cfg_reg.one_shot || armed_reg);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      align_reg <= 1'b0;
    end else if (ce_i) begin
      align_reg <= align_fire;
    end
  end

  // ****************************************************************
  // Validity gating
  // ****************************************************************

  // pulse reference must also be valid
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ref_a_valid_reg <= 1'b0;
      ref_c_valid_reg <= 1'b0;
    end else if (ce_i) begin
      ref_a_valid_reg <= ref_a_valid_i && (!cfg_reg.validate || ref_b_valid_i);
      ref_c_valid_reg <= ref_c_valid_i && (!cfg_reg.validate || ref_d_valid_i);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Status byte, upper bits zero
  always_comb begin
    status_byte                     = 8'h00;
    status_byte[fpa_pkg::ST_ARMED]  = armed_reg;
    status_byte[fpa_pkg::ST_ENABLE] = cfg_reg.enable;
    status_byte[fpa_pkg::ST_DONE]   = done_reg;
    status_byte[fpa_pkg::ST_PIN]    = pin_level[fpa_pkg::PIN_ARM];
  end

  // Read mux, unmapped reads zero
  always_comb begin
    rd_data_next = 8'h00;
    if (bus_req_i.rd) begin
      unique case (bus_req_i.addr)
        fpa_pkg::ADDR_ENABLE: begin
          rd_data_next[fpa_pkg::BIT_ENABLE] = shadow_reg.enable;
        end
        fpa_pkg::ADDR_SETTING: begin
          rd_data_next = fpa_pkg::fpa_setting_byte(shadow_reg);
        end
        fpa_pkg::ADDR_STATUS: begin
          rd_data_next = status_byte;
        end
        default: begin
          rd_data_next = 8'h00;
        end
      endcase
    end
  end

  // Read data stands one cycle only while ce_i is high
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_data_reg <= 8'h00;
    end else if (ce_i) begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_data_o     = rd_data_reg;
  assign ref_a_valid_o = ref_a_valid_reg;
  assign ref_c_valid_o = ref_c_valid_reg;
  assign frame_align_o = align_reg;
  assign armed_o       = armed_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb_sys @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_disabled_no_align: assert property (
    (ce_i && !cfg_reg.enable) |=> !frame_align_o)
    else $error("alignment strobe while disabled");

  a_ref_a_gated: assert property (
    ce_i |=> (ref_a_valid_o == ($past(ref_a_valid_i) && (!$past(cfg_reg.validate) || $past(ref_b_valid_i)))))
    else $error("reference A validity wrong");

  a_ref_c_gated: assert property (
    ce_i |=> (ref_c_valid_o == ($past(ref_c_valid_i) && (!$past(cfg_reg.validate) || $past(ref_d_valid_i)))))
    else $error("reference C validity wrong");

  a_level_every_edge: assert property (
    (ce_i && pulse_edge && !cfg_reg.one_shot) |=> frame_align_o)
    else $error("level mode missed an edge");

  a_one_shot_unarmed: assert property (
    (ce_i && cfg_reg.one_shot && !armed_reg) |=> !frame_align_o)
    else $error("one-shot fired while unarmed");

  a_armed_pulse_fires: assert property (
    (ce_i && pulse_edge && cfg_reg.one_shot && armed_reg && !arm_evt) |=> (frame_align_o && !armed_reg))
    else $error("armed pulse not taken once");

  a_one_shot_used: assert property (
    (ce_i && align_fire && cfg_reg.one_shot && !arm_evt) |=> done_reg)
    else $error("one-shot use not recorded");

  a_update_loads: assert property (
    (ce_i && update_stb) |=> (cfg_reg == $past(shadow_reg)))
    else $error("update did not load configuration");

  a_no_update_hold: assert property (
    !(ce_i && update_stb) |=> $stable(cfg_reg))
    else $error("configuration changed without update");

  // pin source arms on falling edge
  a_pin_source_arms: assert property (
    (ce_i && cfg_eff.enable && !cfg_eff.arm_src && pin_fall[fpa_pkg::PIN_ARM]) |=> armed_reg)
    else $error("pin falling edge did not arm");

  // soft arm takes effect at update
  a_soft_arm_update: assert property (
    (ce_i && soft_arm_evt && shadow_reg.enable) |=> armed_reg)
    else $error("soft arm did not arm at update");

  // soft bit inert with pin source
  a_soft_needs_src: assert property (
    (ce_i && !armed_reg && !cfg_eff.arm_src && !pin_fall[fpa_pkg::PIN_ARM]) |=> !armed_reg)
    else $error("armed without selected source");

  // Unmapped read answers zero next cycle
  a_unmapped_zero: assert property (
    (ce_i && bus_req_i.rd && (bus_req_i.addr != fpa_pkg::ADDR_ENABLE) &&
     (bus_req_i.addr != fpa_pkg::ADDR_SETTING) && (bus_req_i.addr != fpa_pkg::ADDR_STATUS))
    |=> (rd_data_o == 8'h00))
    else $error("unmapped read not zero");

  // Clock enable low holds armed flag, both configuration copies and read data
  a_ce_freeze_state: assert property (
    !ce_i |=> ($stable(armed_reg) && $stable(cfg_reg) && $stable(shadow_reg) && $stable(rd_data_o)))
    else $error("state moved while clock enable low");

  // Main scenarios
  c_level_align: cover property (pulse_edge && !cfg_reg.one_shot ##1 frame_align_o);
  c_one_shot_fire: cover property (armed_reg && cfg_reg.one_shot && pulse_edge ##1 frame_align_o);
  c_soft_arm: cover property (soft_arm_evt ##1 armed_reg);
  c_pin_arm: cover property (pin_arm_evt ##1 armed_reg);

endmodule

// >>> bench/fpa_pulse_src.sv
// Frame pulse and arm pin source standing outside the alignment block
`timescale 1ns/100ps
module fpa_pulse_src (
  input  logic       clk_sys_i,
  input  logic [2:0] fire_i,
  output logic       pulse_b_o,
  output logic       pulse_d_o,
  output logic       arm_pin_o
);
  int hold [3] = '{0, 0, 0};

  // ****************************************************************
  // Pulse and arm pin generation
  // ****************************************************************
  // Arm pin driven high, then low
  // Frame pulses on B and D
  // Each request gives four cycles high, then low; moved off the edge
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < 3; i++) begin
      if (fire_i[i]) hold[i] = 4;
      else if (hold[i] > 0) hold[i] = hold[i] - 1;
    end
    #3;
    pulse_b_o = hold[0] > 0;
    pulse_d_o = hold[1] > 0;
    arm_pin_o = hold[2] > 0;
  end

  // Lines idle low from time zero
  initial begin
    pulse_b_o = 1'b0;
    pulse_d_o = 1'b0;
    arm_pin_o = 1'b0;
  end
endmodule

// >>> bench/frame_pulse_alignment_control_tb_top.sv
// Self-checking bench for the frame-pulse alignment control block
`timescale 1ns/100ps
module frame_pulse_alignment_control_tb_top;
  logic                     clk_sys_i = 1'b0;
  logic                     rst_i     = 1'b1;
  logic                     ce_i      = 1'b1;
  fpa_pkg::fpa_bus_req_type bus_req   = '0;
  logic [3:0]               valid_in  = 4'h0;
  logic                     c_sel     = 1'b0;
  logic [2:0]               fire      = 3'h0;
  logic [15:0]              lfsr      = 16'hca68;
  logic [7:0]               rd_data;
  logic                     pulse_b;
  logic                     pulse_d;
  logic                     arm_pin;
  logic                     ref_a_v;
  logic                     ref_c_v;
  logic                     align;
  logic                     armed;
  logic [7:0]               sh_en     = 8'h00;
  logic [7:0]               sh_set    = 8'h00;
  logic [7:0]               act_en    = 8'h00;
  logic [7:0]               act_set   = 8'h00;
  logic                     m_armed   = 1'b0;
  int                       n_fail    = 0;
  int                       checked   = 0;
  int                       seen_cnt  = 0;
  int                       exp_cnt   = 0;

  // ****************************************************************
  // Clock, design and far side
  // ****************************************************************
  always #5 clk_sys_i = ~clk_sys_i;

  fpa_frame_align_ctrl dut (
    .clk_sys_i       (clk_sys_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .bus_req_i       (bus_req),
    .rd_data_o       (rd_data),
    .arm_pin_i       (arm_pin),
    .pulse_b_i       (pulse_b),
    .pulse_d_i       (pulse_d),
    .ref_a_valid_i   (valid_in[0]),
    .ref_b_valid_i   (valid_in[1]),
    .ref_c_valid_i   (valid_in[2]),
    .ref_d_valid_i   (valid_in[3]),
    .ref_c_selected_i(c_sel),
    .ref_a_valid_o   (ref_a_v),
    .ref_c_valid_o   (ref_c_v),
    .frame_align_o   (align),
    .armed_o         (armed)
  );

  fpa_pulse_src u_src (
    .clk_sys_i(clk_sys_i),
    .fire_i   (fire),
    .pulse_b_o(pulse_b),
    .pulse_d_o(pulse_d),
    .arm_pin_o(arm_pin)
  );

  // Counts realign pulses away from the launching edge
  always @(negedge clk_sys_i) begin
    if (align === 1'b1) seen_cnt = seen_cnt + 1;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One bus cycle; the next call or idle replaces it at the next edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
  endtask

  task automatic idle();
    @(posedge clk_sys_i);
    bus_req <= '0;
  endtask

  // Model of shadow and active copies, then the write itself
  task automatic bw(input logic [15:0] a, input logic [7:0] d);
    logic prev;
    prev = act_set[1] & act_set[0];
    if (a == 16'h0640) sh_en = d & 8'h01;
    if (a == 16'h0641) sh_set = d & 8'h0f;
    if (a == 16'h0005 && d[0]) begin
      act_en  = sh_en;
      act_set = sh_set;
      if (act_set[1] & act_set[0] & ~prev) m_armed = 1'b1;
      if (act_set[1] & ~act_set[0]) m_armed = 1'b0;
      if (~act_en[0]) m_armed = 1'b0;
    end
    bus(1'b1, a, d);
  endtask

  // Read; data looked at in the one cycle where it stands
  task automatic rd(input logic [15:0] a);
    logic [7:0] e;
    e = (a == 16'h0640) ? sh_en : (a == 16'h0641) ? sh_set :
        (a == 16'h0642) ? {6'h00, act_en[0], m_armed} : 8'h00;
    bus(1'b0, a, 8'h00);
    idle();
    #1;
    check(rd_data, e);
  endtask

  // Far-side event: 0 pulse B, 1 pulse D, 2 arm pin; model follows
  // Only the pulse of the selected reference counts, and none while frozen
  task automatic fire_one(input int i);
    @(posedge clk_sys_i);
    fire <= 3'(1 << i);
    @(posedge clk_sys_i);
    fire <= 3'h0;
    repeat (12) @(posedge clk_sys_i);
    if (i == 2) begin
      if (~act_set[1] & act_en[0] & ce_i) m_armed = 1'b1;
    end else if (act_en[0] && ce_i && (i == int'(c_sel))) begin
      if (~act_set[2]) exp_cnt++;
      else if (m_armed) begin
        exp_cnt++;
        m_armed = 1'b0;
      end
    end
  endtask

  task automatic verify();
    repeat (2) @(posedge clk_sys_i);
    #1;
    check(seen_cnt[7:0], exp_cnt[7:0]);
    check({7'h0, armed}, {7'h0, m_armed});
  endtask

  // Random validity flags, output one cycle after the inputs
  task automatic valid_sweep();
    logic [3:0] v;
    for (int k = 0; k < 24; k++) begin
      @(posedge clk_sys_i);
      lfsr = lfsr_next(lfsr);
      v = lfsr[3:0];
      valid_in <= v;
      c_sel <= lfsr[4];
      @(posedge clk_sys_i);
      #1;
      check({7'h0, ref_a_v}, {7'h0, v[0] & (~act_set[3] | v[1])});
      check({7'h0, ref_c_v}, {7'h0, v[2] & (~act_set[3] | v[3])});
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(16'h0640);
    rd(16'h0641);
    rd(16'h0643);
    rd(16'h0005);
    // Enable written but not yet in force
    bw(16'h0640, {lfsr[7:1], 1'b1});
    idle();
    fire_one(0);
    verify();
    rd(16'h0640);
    // Level mode realigns on every B pulse, no arming needed; the D pulse is ignored
    bw(16'h0005, 8'h01);
    idle();
    fire_one(0);
    fire_one(0);
    fire_one(1);
    verify();
    // Clock enable low freezes the synchronisers, so this pulse is lost
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    fire_one(0);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    verify();
    valid_sweep();
    bw(16'h0641, 8'h08);
    bw(16'h0005, 8'h01);
    idle();
    valid_sweep();
    // One-shot armed from the pin
    bw(16'h0641, 8'h04);
    bw(16'h0005, 8'h01);
    idle();
    fire_one(0);
    verify();
    fire_one(2);
    verify();
    fire_one(0);
    fire_one(1);
    verify();
    fire_one(2);
    fire_one(1);
    verify();
    // Soft arm bit without the source bit, then pin while soft selected
    bw(16'h0641, 8'h05);
    bw(16'h0005, 8'h01);
    idle();
    fire_one(0);
    verify();
    bw(16'h0641, 8'h06);
    bw(16'h0005, 8'h01);
    idle();
    fire_one(2);
    verify();
    bw(16'h0641, 8'h07);
    idle();
    verify();
    rd(16'h0641);
    bw(16'h0005, 8'h01);
    idle();
    verify();
    fire_one(1);
    fire_one(0);
    verify();
    // Re-arm by clearing and setting the soft bit, then disable
    bw(16'h0641, 8'h06);
    bw(16'h0005, 8'h01);
    bw(16'h0641, 8'h07);
    bw(16'h0005, 8'h01);
    idle();
    verify();
    rd(16'h0642);
    bw(16'h0640, 8'h00);
    bw(16'h0005, 8'h01);
    idle();
    fire_one(0);
    verify();
    rd(16'h0642);
    complete_run();
  end

  // Bound on the whole run
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
endmodule
